// *** common/drss_defines.svh ***
/*
  shared constants of the dual rail sequencer supervisor core.
  assumes a 50 MHz clock; included by bare name.
*/
`ifndef DRSS_DEFINES_SVH
`define DRSS_DEFINES_SVH
`define DRSS_CLK_HZ 50000000
`define DRSS_RELEASE_MS 120
`define DRSS_MS_PER_S 1000
`define DRSS_RELEASE_CYCLES ((`DRSS_CLK_HZ / `DRSS_MS_PER_S) * `DRSS_RELEASE_MS)
`define DRSS_SYNC_STAGES 2
`define DRSS_IN_WIDTH 8
// synchroniser reset: shutdown, order select and both clears at their idle high level
`define DRSS_SYNC_IDLE 8'hf0
`define DRSS_APB_STATUS 12'h000
`define DRSS_APB_MASK 12'h004
`define DRSS_APB_LEVEL 12'h008
`define DRSS_EV_WIDTH 4
`define DRSS_EV_RST_ASSERT 0
`define DRSS_EV_RST_RELEASE 1
`define DRSS_EV_PG1_FALL 2
`define DRSS_EV_RAIL2_FALL 3
`endif

// *** common/drss_pkg.sv ***
/*
  types of the dual rail sequencer supervisor core.
  assumes drss_defines.svh is on the include path.
*/
`include "drss_defines.svh"
package drss_pkg;
  typedef enum logic [1:0] {DRSS_SLEEP, DRSS_FIRST, DRSS_BOTH} drss_seq_t;
  typedef struct packed {
    logic shutdownN;
    logic orderSelect;
    logic manualClearAN;
    logic manualClearBN;
    logic rail1At83;
    logic rail1At95;
    logic rail2At83;
    logic rail2At95;
  } drss_in_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } drss_apb_req_t;
endpackage

// *** design/drss_sync.sv ***
/*
  two flop synchroniser for a vector of level inputs.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
`include "drss_defines.svh"
module drss_sync
#(
  parameter int WIDTH = `DRSS_IN_WIDTH,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  input wire logic clock, // system clock
  input wire logic rst_n, // synchronous reset, low active
  input wire logic [WIDTH-1:0] din, // asynchronous levels
  output logic [WIDTH-1:0] dout // synchronised levels
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_dout;

  if (WIDTH < 1)
  begin
    $error("drss_sync width must be positive");
  end

  // stage one feeds only stage two, never any logic
  always_comb
  begin
    next_stage1 = din;
    next_dout = stage1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      stage1 <= RESET_VALUE;
      dout <= RESET_VALUE;
    end
    else
    begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end
endmodule

// *** design/drss_core.sv ***
/*
  sequencer and supervisor core of a dual rail regulator with an apb
  status window and one interrupt line.
  assumes comparator levels from outside, the open-drain pins resolved
  by the bench from the enables, and a free-running 50 MHz clock.
*/
`timescale 1ns/1ns
`include "drss_defines.svh"
module drss_core
import drss_pkg::*;
#(
  parameter int RELEASE_CYCLES = `DRSS_RELEASE_CYCLES
)
(
  input wire logic clock, // 50 MHz free-running clock
  input wire logic rst_n, // synchronous reset, low active
  input wire logic shutdownN, // low enables the device
  input wire logic orderSelect, // high: rail two first
  input wire logic manualClearAN, // manual clear a, low active
  input wire logic manualClearBN, // manual clear b, low active
  input wire logic rail1At83, // rail one above 83 percent
  input wire logic rail1At95, // rail one above 95 percent
  input wire logic rail2At83, // rail two above 83 percent
  input wire logic rail2At95, // rail two above 95 percent
  output logic rail1Enable, // rail one regulator on
  output logic rail2Enable, // rail two regulator on
  output logic railOneGoodOe, // low releases rail one good pin
  output logic supervisorOe, // low releases supervisor reset pin
  output logic sleeping, // low current sleep state
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic irq // level interrupt
);
  localparam int CW = $clog2(RELEASE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(RELEASE_CYCLES - 1);

  drss_in_t raw;
  drss_in_t syn;
  drss_seq_t state;
  drss_seq_t next_state;
  logic firstIsRail2;
  logic next_firstIsRail2;
  logic [CW-1:0] delayCount;
  logic [CW-1:0] next_delayCount;
  logic resetReleased;
  logic next_resetReleased;
  logic next_rail1Enable;
  logic next_rail2Enable;
  logic next_railOneGoodOe;
  logic next_supervisorOe;
  logic next_sleeping;
  logic [`DRSS_EV_WIDTH-1:0] status;
  logic [`DRSS_EV_WIDTH-1:0] next_status;
  logic [`DRSS_EV_WIDTH-1:0] mask;
  logic [`DRSS_EV_WIDTH-1:0] next_mask;
  logic [`DRSS_EV_WIDTH-1:0] events;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;
  logic releaseCond;
  logic prevPg1;
  logic prevRail2;
  logic next_prevPg1;
  logic next_prevRail2;
  logic access;
  logic wrStatus;
  logic wrMask;
  logic mapped;

  // the release check below watches eight cycles, so delays of eight cycles or fewer are refused
  if (RELEASE_CYCLES < 9)
  begin
    $error("release delay must be at least nine cycles");
  end

  // idle levels of a sleeping, unclocked device are shutdown high and clears high
  assign raw = '{shutdownN, orderSelect, manualClearAN, manualClearBN, rail1At83, rail1At95, rail2At83, rail2At95};

  drss_sync #(.WIDTH(`DRSS_IN_WIDTH), .RESET_VALUE(`DRSS_SYNC_IDLE)) u_sync
  (
    .clock(clock),
    .rst_n(rst_n),
    .din(raw),
    .dout(syn)
  );

  // power-up order; the order is latched on wake so a mid-run toggle cannot glitch rails
  always_comb
  begin
    next_state = state;
    next_firstIsRail2 = firstIsRail2;
    next_rail1Enable = 1'b0;
    next_rail2Enable = 1'b0;
    next_sleeping = 1'b0;
    case (state)
      DRSS_SLEEP:
      begin
        next_sleeping = 1'b1;
        if (!syn.shutdownN)
        begin
          next_state = DRSS_FIRST;
          next_firstIsRail2 = syn.orderSelect;
          next_sleeping = 1'b0;
        end
      end
      DRSS_FIRST, DRSS_BOTH:
      begin
        // rail two first, rail one gated by rail two at 83 percent
        // rail one drops whenever rail two falls under 83 percent
        if (firstIsRail2)
        begin
          next_rail2Enable = 1'b1;
          next_rail1Enable = syn.rail2At83;
          next_state = syn.rail2At83 ? DRSS_BOTH : DRSS_FIRST;
        end
        // rail two waits for rail one at 83 percent, then stays on
        else
        begin
          next_rail1Enable = 1'b1;
          next_rail2Enable = (state == DRSS_BOTH) || syn.rail1At83;
          next_state = next_rail2Enable ? DRSS_BOTH : DRSS_FIRST;
        end
      end
      default:
      begin
        next_state = DRSS_SLEEP;
      end
    endcase
    if (syn.shutdownN)
    begin
      next_state = DRSS_SLEEP;
      next_rail1Enable = 1'b0;
      next_rail2Enable = 1'b0;
      next_sleeping = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state <= DRSS_SLEEP;
      firstIsRail2 <= 1'b1;
      rail1Enable <= 1'b0;
      rail2Enable <= 1'b0;
      sleeping <= 1'b1;
    end
    else
    begin
      state <= next_state;
      firstIsRail2 <= next_firstIsRail2;
      rail1Enable <= next_rail1Enable;
      rail2Enable <= next_rail2Enable;
      sleeping <= next_sleeping;
    end
  end

  // release condition uses rail two, both manual clears and shutdown low
  assign releaseCond = syn.rail2At95 && syn.manualClearAN && syn.manualClearBN && !syn.shutdownN;

  // supervisor and power good pins
  always_comb
  begin
    next_delayCount = delayCount;
    next_resetReleased = resetReleased;
    // restart on any drop, cleared in shutdown
    if (!releaseCond)
    begin
      next_delayCount = '0;
      next_resetReleased = 1'b0;
    end
    // release only after the full delay
    else if (!resetReleased)
    begin
      if (delayCount == LAST)
      begin
        next_resetReleased = 1'b1;
      end
      else
      begin
        next_delayCount = delayCount + CW'(1);
      end
    end
    // rail two low asserts reset at once
    next_supervisorOe = !next_resetReleased;
    // release good once rail one at 95 percent
    // drive good low under 95 percent
    next_railOneGoodOe = !(syn.rail1At95 && !syn.shutdownN);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      delayCount <= '0;
      resetReleased <= 1'b0;
      supervisorOe <= 1'b1; // both pins pulled low while the block is held in reset
      railOneGoodOe <= 1'b1;
    end
    else
    begin
      delayCount <= next_delayCount;
      resetReleased <= next_resetReleased;
      supervisorOe <= next_supervisorOe;
      railOneGoodOe <= next_railOneGoodOe;
    end
  end

  // apb slave with one wait state; writes land at the edge that samples pready high
  assign access = psel && penable && !pready;
  assign mapped = (paddr == `DRSS_APB_STATUS) || (paddr == `DRSS_APB_MASK) || (paddr == `DRSS_APB_LEVEL);
  assign wrStatus = psel && penable && pready && pwrite && (paddr == `DRSS_APB_STATUS);
  assign wrMask = psel && penable && pready && pwrite && (paddr == `DRSS_APB_MASK);

  // events: reset asserted, reset released, good fell, rail two fell
  always_comb
  begin
    events = '0;
    events[`DRSS_EV_RST_ASSERT] = resetReleased && !next_resetReleased;
    events[`DRSS_EV_RST_RELEASE] = !resetReleased && next_resetReleased;
    events[`DRSS_EV_PG1_FALL] = prevPg1 && !syn.rail1At95;
    events[`DRSS_EV_RAIL2_FALL] = prevRail2 && !syn.rail2At95;
    next_prevPg1 = syn.rail1At95;
    next_prevRail2 = syn.rail2At95;
    next_mask = wrMask ? pwdata[`DRSS_EV_WIDTH-1:0] : mask;
    // set wins over a write-one clear in the same cycle
    next_status = (wrStatus ? (status & ~pwdata[`DRSS_EV_WIDTH-1:0]) : status) | events;
    next_irq = |(next_status & next_mask);
    next_pready = access;
    next_pslverr = access && !mapped;
    next_prdata = '0;
    if (access && !pwrite)
    begin
      case (paddr)
        `DRSS_APB_STATUS: next_prdata = {28'h0000000, status};
        `DRSS_APB_MASK: next_prdata = {28'h0000000, mask};
        `DRSS_APB_LEVEL: next_prdata = {25'h0, sleeping, firstIsRail2, rail1Enable, rail2Enable,
                                         !railOneGoodOe, !supervisorOe, syn.shutdownN};
        default: next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      status <= '0;
      mask <= '0;
      prevPg1 <= 1'b0;
      prevRail2 <= 1'b0;
      irq <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      status <= next_status;
      mask <= next_mask;
      prevPg1 <= next_prevPg1;
      prevRail2 <= next_prevRail2;
      irq <= next_irq;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  sleep_rails_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    syn.shutdownN |=> !rail1Enable && !rail2Enable && sleeping)
    else $error("rail enabled during shutdown");
  wake_from_sleep_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state == DRSS_SLEEP && !syn.shutdownN) |=> !sleeping)
    else $error("no wake on shutdown low");
  // rail one follows rail two threshold
  rail1_gated_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state != DRSS_SLEEP && firstIsRail2 && !syn.rail2At83 && !syn.shutdownN) |=> !rail1Enable)
    else $error("rail one on while rail two low");
  // rail two waits for rail one
  rail2_waits_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state == DRSS_FIRST && !firstIsRail2 && !syn.rail1At83) |=> !rail2Enable)
    else $error("rail two on before rail one");
  good_follows_a: assert property (@(posedge clock) disable iff (!rst_n)
    !syn.rail1At95 |=> railOneGoodOe)
    else $error("good released with rail one low");
  good_release_a: assert property (@(posedge clock) disable iff (!rst_n)
    (syn.rail1At95 && !syn.shutdownN) |=> !railOneGoodOe)
    else $error("good not released with rail one up");
  // manual clear forces reset within pipeline latency
  clear_resets_a: assert property (@(posedge clock) disable iff (!rst_n)
    !syn.manualClearAN || !syn.manualClearBN |=> supervisorOe)
    else $error("reset not asserted by manual clear");
  reset_on_fall_a: assert property (@(posedge clock) disable iff (!rst_n)
    !syn.rail2At95 |=> supervisorOe)
    else $error("reset not asserted on rail two fall");
  // reset stays asserted before full delay
  release_delay_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(releaseCond) |=> supervisorOe [*8])
    else $error("reset released too early");
  count_restart_a: assert property (@(posedge clock) disable iff (!rst_n)
    !releaseCond |=> delayCount == '0)
    else $error("delay counter not cleared");
endmodule

// *** tb/drss_rail_model.sv ***
/*
  behavioural rails: each output ramps while enabled, drops on fault.
  assumes level comparators with no hysteresis.
*/
`timescale 1ns/1ns
module drss_rail_model
(
  input wire logic clock, // system clock
  input wire logic rail1Enable, // rail one on
  input wire logic rail2Enable, // rail two on
  input wire logic fault1, // overload rail one
  input wire logic fault2, // overload rail two
  output logic rail1At83, // rail one above 83
  output logic rail1At95, // rail one above 95
  output logic rail2At83, // rail two above 83
  output logic rail2At95 // rail two above 95
);
  logic [2:0] level1 = 3'h0;
  logic [2:0] level2 = 3'h0;
  // one step a cycle, so the thresholds trail the enable
  always_ff @(posedge clock)
  begin
    level1 <= (!rail1Enable || fault1) ? 3'h0 : level1 + {2'h0, level1 != 3'h6};
    level2 <= (!rail2Enable || fault2) ? 3'h0 : level2 + {2'h0, level2 != 3'h6};
  end
  // thresholds taken from the ramp
  assign rail1At83 = level1 >= 3'h3;
  assign rail1At95 = level1 >= 3'h5;
  assign rail2At83 = level2 >= 3'h3;
  assign rail2At95 = level2 >= 3'h5;
endmodule

// *** tb/dual_rail_sequencer_supervisor_bench.sv ***
/*
  self-checking bench for the sequencer core with a rail model.
  assumes the open-drain pins have pull-ups and short release count.
*/
`timescale 1ns/1ns
module dual_rail_sequencer_supervisor_bench;
  logic clock, rst_n, shutdownN, orderSelect, manualClearAN, fault1, fault2;
  logic psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rail1At83, rail1At95, rail2At83, rail2At95;
  logic rail1Enable, rail2Enable, railOneGoodOe, supervisorOe, sleeping;
  int fails, totalChecks, cycles, n;

  // good pin routed into clear b
  drss_core #(.RELEASE_CYCLES(20)) u_dut (.clock(clock), .rst_n(rst_n), .shutdownN(shutdownN),
    .orderSelect(orderSelect), .manualClearAN(manualClearAN), .manualClearBN(!railOneGoodOe),
    .rail1At83(rail1At83), .rail1At95(rail1At95), .rail2At83(rail2At83), .rail2At95(rail2At95),
    .rail1Enable(rail1Enable), .rail2Enable(rail2Enable), .railOneGoodOe(railOneGoodOe),
    .supervisorOe(supervisorOe), .sleeping(sleeping), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  drss_rail_model u_rails (.clock(clock), .rail1Enable(rail1Enable), .rail2Enable(rail2Enable),
    .fault1(fault1), .fault2(fault2), .rail1At83(rail1At83), .rail1At95(rail1At95),
    .rail2At83(rail2At83), .rail2At95(rail2At95));

  // free-running 50 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task report_and_stop;
    if (fails == 0 && totalChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles used
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      report_and_stop();
    end
  end

  task chk(input string what, input logic exp, input logic got);
    totalChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task tick(input int k);
    repeat (k) @(posedge clock);
  endtask

  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no wait count is assumed; only the hang guard ends a lost answer
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // count cycles until the supervisor pin is released
  task release_time;
    n = 0;
    while (supervisorOe !== 1'b0 && n < 60)
    begin
      tick(1);
      n++;
    end
    chk("release delay", 1'b1, n >= 19 && n <= 26);
  endtask

  task t_order_high;
    orderSelect <= 1'b1;
    shutdownN <= 1'b0;
    for (int i = 0; i < 20 && rail2Enable !== 1'b1; i++) tick(1);
    chk("rail2 on", 1'b1, rail2Enable);
    chk("rail1 waits", 1'b0, rail1Enable);
    for (int i = 0; i < 20 && rail1Enable !== 1'b1; i++) tick(1);
    chk("rail2 at 83", 1'b1, rail2At83);
    for (int i = 0; i < 20 && railOneGoodOe !== 1'b0; i++) tick(1);
    chk("good released", 1'b1, rail1At95);
    release_time();
    manualClearAN <= 1'b0;
    tick(5);
    chk("clear a asserts", 1'b1, supervisorOe);
    chk("rails stay", 1'b1, rail1Enable & rail2Enable);
    manualClearAN <= 1'b1;
    release_time();
    fault1 <= 1'b1;
    tick(6);
    chk("good low", 1'b1, railOneGoodOe);
    chk("rail2 kept", 1'b1, rail2Enable);
    fault1 <= 1'b0;
    // rail one must ramp back before the release window is timed
    for (int i = 0; i < 20 && railOneGoodOe !== 1'b0; i++) tick(1);
    chk("good back", 1'b0, railOneGoodOe);
    release_time();
    fault2 <= 1'b1;
    tick(6);
    chk("rail1 dropped", 1'b0, rail1Enable);
    chk("reset on fall", 1'b1, supervisorOe);
    fault2 <= 1'b0;
    shutdownN <= 1'b1;
    tick(6);
    chk("off in shutdown", 1'b0, rail1Enable | rail2Enable);
    chk("asleep", 1'b1, sleeping);
  endtask

  task t_order_low;
    orderSelect <= 1'b0;
    shutdownN <= 1'b0;
    for (int i = 0; i < 20 && rail1Enable !== 1'b1; i++) tick(1);
    chk("rail2 waits", 1'b0, rail2Enable);
    for (int i = 0; i < 20 && rail2Enable !== 1'b1; i++) tick(1);
    chk("rail1 at 83", 1'b1, rail1At83);
    shutdownN <= 1'b1;
    tick(12);
  endtask

  // status, mask, level and an unmapped word
  task t_regs;
    apb(1'b1, 12'h004, 32'h00000002);
    tick(2);
    chk("irq raised", 1'b1, irq);
    apb(1'b1, 12'h000, 32'h0000000f);
    tick(2);
    chk("irq cleared", 1'b0, irq);
    apb(1'b0, 12'h000, 32'h00000000);
    chk32("status", 32'h00000000, rd);
    apb(1'b0, 12'h008, 32'h00000000);
    chk32("level", 32'h00000041, rd & 32'h00000041);
    apb(1'b0, 12'h00c, 32'h00000000);
    chk("unmapped", 1'b1, err);
  endtask

  initial
  begin
    rst_n = 1'b0;
    shutdownN = 1'b1;
    orderSelect = 1'b1;
    manualClearAN = 1'b1;
    fault1 = 1'b0;
    fault2 = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    tick(5);
    rst_n <= 1'b1;
    tick(4);
    chk("sleep enables", 1'b0, rail1Enable | rail2Enable);
    t_order_high();
    t_order_low();
    t_regs();
    report_and_stop();
  end
endmodule
